// >>> core/epsl_pkg.sv
// Shared constants and types for the program memory programming and
// security block. Assumes a single 10 MHz clock and a classic Wishbone host.
package epsl_pkg;

   // Clock and verify timing
   localparam int CLOCK_HZ          = 10_000_000;
   localparam int OSC_MAX_HZ        = 6_000_000;
   localparam int VERIFY_MAX_OSC    = 48;
   localparam int VERIFY_MAX_CYCLES = (VERIFY_MAX_OSC * CLOCK_HZ) / OSC_MAX_HZ;
   localparam int VERIFY_LATENCY    = 3;

   // Programming pulse count per byte or bit
   localparam logic [2:0] PROG_PULSES = 3'h5;

   // Memory geometry
   localparam int PIN_AW   = 14;
   localparam int CODE_AW  = 12;
   localparam int ENC_AW   = 6;
   localparam int ENC_SIZE = 64;

   // Erased byte value
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // Signature locations
   localparam logic [PIN_AW-1:0] SIG_MAKER_ADDR = 14'h0030;
   localparam logic [PIN_AW-1:0] SIG_PART_ADDR  = 14'h0031;

   // Mode nibbles {port2_bit7, port2_bit6, port3_bit7, port3_bit6}
   localparam logic [3:0] NIB_SIGNATURE   = 4'h0;
   localparam logic [3:0] NIB_PROG_CODE   = 4'hB;
   localparam logic [3:0] NIB_VERIFY_CODE = 4'h3;
   localparam logic [3:0] NIB_PROG_ENC    = 4'hA;
   localparam logic [3:0] NIB_LOCK1       = 4'hF;
   localparam logic [3:0] NIB_LOCK2       = 4'hC;
   localparam logic [3:0] NIB_LOCK3       = 4'h5;
   localparam logic [3:0] NIB_SIX_CLK     = 4'h2;
   localparam logic [2:0] NIB_VERIFY_SIX  = 3'h1;

   // Status bit positions on port 0
   localparam int P0_LOCK1_BIT = 7;
   localparam int P0_LOCK2_BIT = 6;
   localparam int P0_CLK_BIT   = 4;
   localparam int P0_LOCK3_BIT = 3;

   // Wishbone register byte offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h04;
   localparam logic [7:0] REG_CODE_ADDR = 8'h08;
   localparam logic [7:0] REG_CODE_DATA = 8'h0C;

   // Control fields
   localparam int         CTRL_ALLOW_BIT = 0;
   localparam int         CTRL_CLEAR_BIT = 1;
   localparam logic       CTRL_ALLOW_RST = 1'b1;

   // Status fields
   localparam int STAT_LOCK_LSB  = 0;
   localparam int STAT_ENC_BIT   = 3;
   localparam int STAT_CLK_BIT   = 4;
   localparam int STAT_EA_BIT    = 5;
   localparam int STAT_REFUSED   = 6;
   localparam int STAT_MODE_LSB  = 8;

   typedef enum logic [3:0] {
      MODE_NONE,
      MODE_SIGNATURE,
      MODE_PROG_CODE,
      MODE_VERIFY_CODE,
      MODE_PROG_ENC,
      MODE_PROG_LOCK1,
      MODE_PROG_LOCK2,
      MODE_PROG_LOCK3,
      MODE_PROG_SIX_CLK,
      MODE_VERIFY_SIX_CLK,
      MODE_VERIFY_LOCK
   } epsl_mode_t;

   typedef enum logic [1:0] {
      PG_IDLE,
      PG_LOW,
      PG_HIGH
   } epsl_pg_t;

endpackage : epsl_pkg

// >>> core/epsl_mode_decode.sv
// Registered decoder of the programming mode from the strap pins.
// Assumes the pins are synchronous to clock.
`timescale 1ns/1ns
module epsl_mode_decode
   import epsl_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // Strap pins
   input  wire logic rst_pin,
   input  wire logic program_store_enable,
   input  wire logic port2_bit7,
   input  wire logic port2_bit6,
   input  wire logic port3_bit7,
   input  wire logic port3_bit6,
   input  wire logic port3_bit3,
   // Decoded mode
   output epsl_mode_t mode
);

   logic [3:0] nib;
   epsl_mode_t next_mode;

   assign nib = {port2_bit7, port2_bit6, port3_bit7, port3_bit6};

   always_comb begin
      next_mode = MODE_NONE;
      if (rst_pin && !program_store_enable) begin
         case (nib)
            NIB_SIGNATURE:   next_mode = MODE_SIGNATURE;
            NIB_PROG_CODE:   next_mode = MODE_PROG_CODE;
            NIB_VERIFY_CODE: next_mode = MODE_VERIFY_CODE;
            NIB_PROG_ENC:    next_mode = MODE_PROG_ENC;
            NIB_LOCK1:       next_mode = MODE_PROG_LOCK1;
            NIB_LOCK2:       next_mode = MODE_PROG_LOCK2;
            NIB_LOCK3:       next_mode = MODE_PROG_LOCK3;
            NIB_SIX_CLK:     next_mode = port3_bit3 ? MODE_VERIFY_LOCK : MODE_PROG_SIX_CLK;
            default: begin
               if (nib[2:0] == NIB_VERIFY_SIX && port3_bit3) begin
                  next_mode = MODE_VERIFY_SIX_CLK;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mode <= MODE_NONE;
      end else begin
         mode <= next_mode;
      end
   end

endmodule : epsl_mode_decode

// >>> core/epsl_core.sv
// One-time-programmable code memory with programming, verify and lock logic.
// Assumes programmer pins synchronous to clock and a classic Wishbone host.
//
// Contract
// - With no lock bit set, verify mode reads back code memory.
// - Once encryption is programmed, verify shows encrypted bytes while lock bits two and three are clear.
// - Lock one: block external table reads, latch external access, refuse programming.
// - Locks one and two: lock one restrictions plus verify disabled.
// - All three locks: lower restrictions plus no external code execution.
// - All three locks also make internal data RAM inaccessible.
// - 64-byte encryption array reads as all ones until programmed.
// - Reset high, store enable low, four port pins select the mode.
// - Verify clock mode drives stored clock bit on port0_bit4.
// - Verify lock mode drives lock bits on port0 bits 7, 6, 3.
// - Verify data valid on port 0 within 48 oscillator periods.
// - Verify byte is code XNOR key byte; key array never readable.
// - Signature mode verifies locations 030h and 031h as identity bytes.
// - Remaining lock bits stay programmable after a lock is set.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module epsl_core
   import epsl_pkg::*;
#(
   parameter int         CODE_W    = CODE_AW,
   // Identity bytes: values arbitrary
   parameter logic [7:0] SIG_MAKER = 8'h5A,
   parameter logic [7:0] SIG_PART  = 8'hA5
)
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        resetn,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Programmer pins
   input  wire logic        rst_pin,
   input  wire logic        program_store_enable,
   input  wire logic        prog_pulse_strobe,
   input  wire logic        external_access_prog_voltage,
   input  wire logic [7:0]  port1_in,
   input  wire logic [7:0]  port2_in,
   input  wire logic        port3_bit7,
   input  wire logic        port3_bit6,
   input  wire logic        port3_bit3,
   input  wire logic [7:0]  port0_in,
   output logic      [7:0]  port0_out,
   output logic             port0_oe,
   // Core side
   input  wire logic        external_access_pin,
   input  wire logic        table_read_from_external,
   output logic             code_table_read_instr_block,
   output logic             external_access_effective,
   output logic             external_exec_disable,
   output logic             data_ram_disable,
   output logic             six_clock_mode
);

   epsl_mode_t mode;

   epsl_mode_decode u_mode (
      .clock                (clock),
      .resetn               (resetn),
      .rst_pin              (rst_pin),
      .program_store_enable (program_store_enable),
      .port2_bit7           (port2_in[7]),
      .port2_bit6           (port2_in[6]),
      .port3_bit7           (port3_bit7),
      .port3_bit6           (port3_bit6),
      .port3_bit3           (port3_bit3),
      .mode                 (mode)
   );

   // Storage
   logic [7:0] code_mem [0:(1<<CODE_W)-1];
   logic [7:0] enc_mem  [0:ENC_SIZE-1];

   initial begin
      for (int i = 0; i < (1 << CODE_W); i++) begin
         code_mem[i] = ERASED_BYTE;
      end
   end

   // Nonvolatile flags and programming sequencer state
   logic [2:0]  lock_bits;
   logic        enc_programmed;
   logic        twelve_clock;
   logic        prog_refused;
   logic        ctrl_allow;
   epsl_pg_t    pg_state;
   logic [2:0]  pulse_count;
   logic [2:0]  next_lock_bits;
   logic        next_enc_programmed;
   logic        next_twelve_clock;
   logic        next_prog_refused;
   epsl_pg_t    next_pg_state;
   logic [2:0]  next_pulse_count;
   logic        code_we;
   logic        enc_we;
   logic        ctrl_clear_req;

   logic [PIN_AW-1:0] pin_addr;
   logic              prog_mode;
   logic              commit;
   logic              restrict1;
   logic              restrict2;
   logic              restrict3;

   assign pin_addr  = {port2_in[5:0], port1_in};
   assign prog_mode = (mode == MODE_PROG_CODE) || (mode == MODE_PROG_ENC) ||
                      (mode == MODE_PROG_LOCK1) || (mode == MODE_PROG_LOCK2) ||
                      (mode == MODE_PROG_LOCK3) || (mode == MODE_PROG_SIX_CLK);
   // Higher lock bits imply the lower restrictions
   assign restrict1 = |lock_bits;
   assign restrict2 = lock_bits[1] | lock_bits[2];
   assign restrict3 = lock_bits[2];

   always_comb begin
      next_pg_state       = pg_state;
      next_pulse_count    = pulse_count;
      next_lock_bits      = lock_bits;
      next_enc_programmed = enc_programmed;
      next_twelve_clock   = twelve_clock;
      next_prog_refused   = prog_refused;
      commit              = 1'b0;
      code_we             = 1'b0;
      enc_we              = 1'b0;
      if (ctrl_clear_req) begin
         next_prog_refused = 1'b0;
      end
      if (!prog_mode || !external_access_prog_voltage) begin
         next_pg_state    = PG_IDLE;
         next_pulse_count = 3'h0;
      end else begin
         case (pg_state)
            PG_IDLE: begin
               if (!prog_pulse_strobe) begin
                  next_pg_state = PG_LOW;
               end
            end
            PG_LOW: begin
               if (prog_pulse_strobe) begin
                  next_pg_state = PG_HIGH;
                  if (pulse_count == PROG_PULSES - 3'h1) begin
                     commit           = 1'b1;
                     next_pulse_count = 3'h0;
                  end else begin
                     next_pulse_count = pulse_count + 3'h1;
                  end
               end
            end
            PG_HIGH: begin
               if (!prog_pulse_strobe) begin
                  next_pg_state = PG_LOW;
               end
            end
            default: next_pg_state = PG_IDLE;
         endcase
      end
      if (commit && !ctrl_allow) begin
         next_prog_refused = 1'b1;
      end else if (commit) begin
         case (mode)
            MODE_PROG_LOCK1: next_lock_bits[0] = 1'b1;
            MODE_PROG_LOCK2: next_lock_bits[1] = 1'b1;
            MODE_PROG_LOCK3: next_lock_bits[2] = 1'b1;
            default: begin
               if (restrict1) begin
                  next_prog_refused = 1'b1;
               end
               code_we             = !restrict1 && (mode == MODE_PROG_CODE);
               enc_we              = !restrict1 && (mode == MODE_PROG_ENC);
               next_enc_programmed = enc_programmed || enc_we;
               next_twelve_clock   = twelve_clock && (restrict1 || mode != MODE_PROG_SIX_CLK);
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pg_state       <= PG_IDLE;
         pulse_count    <= 3'h0;
         lock_bits      <= 3'h0;
         enc_programmed <= 1'b0;
         twelve_clock   <= 1'b1;
         prog_refused   <= 1'b0;
      end else begin
         pg_state       <= next_pg_state;
         pulse_count    <= next_pulse_count;
         lock_bits      <= next_lock_bits;
         enc_programmed <= next_enc_programmed;
         twelve_clock   <= next_twelve_clock;
         prog_refused   <= next_prog_refused;
      end
   end

   always @(posedge clock) begin
      if (code_we) begin
         code_mem[pin_addr[CODE_W-1:0]] <= code_mem[pin_addr[CODE_W-1:0]] & port0_in;
      end
   end

   // key array erased to all ones
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < ENC_SIZE; i++) begin
            enc_mem[i] <= ERASED_BYTE;
         end
      end else if (enc_we) begin
         enc_mem[pin_addr[ENC_AW-1:0]] <= enc_mem[pin_addr[ENC_AW-1:0]] & port0_in;
      end
   end

   // Verify path
   logic [7:0] code_byte;
   logic [7:0] verify_byte;
   logic [7:0] next_port0_out;
   logic       next_port0_oe;

   assign code_byte = code_mem[pin_addr[CODE_W-1:0]];
   assign verify_byte = enc_programmed ? ~(code_byte ^ enc_mem[pin_addr[ENC_AW-1:0]])
                                       : code_byte;

   always_comb begin
      next_port0_out = 8'h00;
      next_port0_oe  = 1'b0;
      case (mode)
         MODE_SIGNATURE, MODE_VERIFY_CODE: begin
            next_port0_oe  = !restrict2;
            next_port0_out = restrict2 ? 8'h00 : verify_byte;
            // identity bytes at the signature addresses
            if (mode == MODE_SIGNATURE && pin_addr == SIG_MAKER_ADDR) begin
               next_port0_oe  = 1'b1;
               next_port0_out = SIG_MAKER;
            end else if (mode == MODE_SIGNATURE && pin_addr == SIG_PART_ADDR) begin
               next_port0_oe  = 1'b1;
               next_port0_out = SIG_PART;
            end
         end
         MODE_VERIFY_SIX_CLK: begin
            next_port0_oe              = 1'b1;
            next_port0_out             = ERASED_BYTE;
            next_port0_out[P0_CLK_BIT] = twelve_clock;
         end
         MODE_VERIFY_LOCK: begin
            next_port0_oe                = 1'b1;
            next_port0_out               = ERASED_BYTE;
            next_port0_out[P0_LOCK1_BIT] = !lock_bits[0];
            next_port0_out[P0_LOCK2_BIT] = !lock_bits[1];
            next_port0_out[P0_LOCK3_BIT] = !lock_bits[2];
         end
         default: next_port0_oe = 1'b0;
      endcase
   end

   // data valid within a few cycles
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         port0_out <= 8'h00;
         port0_oe  <= 1'b0;
      end else begin
         port0_out <= next_port0_out;
         port0_oe  <= next_port0_oe;
      end
   end

   // Core-side protection outputs
   logic ea_hold;
   logic next_ea_hold;

   always_comb begin
      // external access caught while reset is high
      next_ea_hold = rst_pin ? external_access_pin : ea_hold;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ea_hold                     <= 1'b0;
         code_table_read_instr_block <= 1'b0;
         external_access_effective   <= 1'b0;
         external_exec_disable       <= 1'b0;
         data_ram_disable            <= 1'b0;
         six_clock_mode              <= 1'b0;
      end else begin
         ea_hold                     <= next_ea_hold;
         code_table_read_instr_block <= restrict1 && table_read_from_external;
         external_access_effective   <= restrict1 ? ea_hold : external_access_pin;
         external_exec_disable       <= restrict3;
         data_ram_disable            <= restrict3;
         six_clock_mode              <= !twelve_clock;
      end
   end

   // Wishbone slave
   logic [CODE_W-1:0] code_addr;
   logic [CODE_W-1:0] next_code_addr;
   logic              next_ctrl_allow;
   logic [31:0]       next_wb_dat_o;
   logic              next_wb_ack_o;
   logic              bus_req;

   assign bus_req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign ctrl_clear_req = bus_req && wb_we_i && (wb_adr_i == REG_CTRL) &&
                           wb_sel_i[0] && wb_dat_i[CTRL_CLEAR_BIT];

   always_comb begin
      next_wb_ack_o   = bus_req;
      next_wb_dat_o   = 32'h0000_0000;
      next_ctrl_allow = ctrl_allow;
      next_code_addr  = code_addr;
      if (bus_req && wb_we_i) begin
         if (wb_adr_i == REG_CTRL) begin
            if (wb_sel_i[0]) begin
               next_ctrl_allow = wb_dat_i[CTRL_ALLOW_BIT];
            end
         end else if (wb_adr_i == REG_CODE_ADDR) begin
            for (int b = 0; b < CODE_W; b++) begin
               if (wb_sel_i[b/8]) begin
                  next_code_addr[b] = wb_dat_i[b];
               end
            end
         end
      end else if (bus_req) begin
         if (wb_adr_i == REG_CTRL) begin
            next_wb_dat_o[CTRL_ALLOW_BIT] = ctrl_allow;
         end else if (wb_adr_i == REG_STATUS) begin
            next_wb_dat_o[STAT_LOCK_LSB +: 3] = lock_bits;
            next_wb_dat_o[STAT_ENC_BIT]       = enc_programmed;
            next_wb_dat_o[STAT_CLK_BIT]       = twelve_clock;
            next_wb_dat_o[STAT_EA_BIT]        = external_access_effective;
            next_wb_dat_o[STAT_REFUSED]       = prog_refused;
            next_wb_dat_o[STAT_MODE_LSB +: 4] = mode;
         end else if (wb_adr_i == REG_CODE_ADDR) begin
            next_wb_dat_o[CODE_W-1:0] = code_addr;
         end else if (wb_adr_i == REG_CODE_DATA) begin
            if (!(restrict1 && table_read_from_external)) begin
               next_wb_dat_o[7:0] = code_mem[code_addr];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0000_0000;
         ctrl_allow <= CTRL_ALLOW_RST;
         code_addr  <= '0;
      end else begin
         wb_ack_o   <= next_wb_ack_o;
         wb_dat_o   <= next_wb_dat_o;
         ctrl_allow <= next_ctrl_allow;
         code_addr  <= next_code_addr;
      end
   end

endmodule : epsl_core

// >>> sim/epsl_core_sva.sv
// Checker for the programming and security core, bound to its ports.
// Assumes one clock and straps driven synchronously to it.
`timescale 1ns/1ns
module epsl_core_sva #(
   parameter logic [7:0] SIG_MAKER = 8'h5A
)
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       resetn,
   // Bus
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   // Programmer pins
   input wire logic       rst_pin,
   input wire logic       program_store_enable,
   input wire logic [7:0] port1_in,
   input wire logic [7:0] port2_in,
   input wire logic       port3_bit7,
   input wire logic       port3_bit6,
   input wire logic       port3_bit3,
   input wire logic [7:0] port0_out,
   input wire logic       port0_oe,
   // Core side
   input wire logic       table_read_from_external,
   input wire logic       code_table_read_instr_block,
   input wire logic       external_exec_disable,
   input wire logic       data_ram_disable,
   input wire logic       six_clock_mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_off; !rst_pin || program_store_enable; endsequence
   sequence s_sig;
      rst_pin && !program_store_enable && port2_in == 8'h00 && !port3_bit7 && !port3_bit6
      && port1_in == 8'h30;
   endsequence
   sequence s_vlock;
      rst_pin && !program_store_enable && port2_in[7:6] == 2'h0 && port3_bit7 && !port3_bit6
      && port3_bit3;
   endsequence
   sequence s_vsix;
      rst_pin && !program_store_enable && !port2_in[6] && !port3_bit7 && port3_bit6 && port3_bit3;
   endsequence
   property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
   property p_refuse; s_off [*3] |-> !port0_oe && port0_out == 8'h00; endproperty
   property p_sig; s_sig [*3] |-> port0_oe && port0_out == SIG_MAKER; endproperty
   property p_vlock;
      s_vlock [*3] |-> port0_oe && port0_out[5:4] == 2'h3 && port0_out[2:0] == 3'h7
      && port0_out[3] == !external_exec_disable;
   endproperty
   property p_vsix; s_vsix [*3] |-> port0_oe && port0_out[4] == !six_clock_mode; endproperty
   property p_ram; data_ram_disable == external_exec_disable; endproperty
   property p_tblk; code_table_read_instr_block |-> $past(table_read_from_external); endproperty
   property p_x3;
      external_exec_disable && table_read_from_external |=> code_table_read_instr_block;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
   a_refuse: assert property (p_refuse) else $error("port 0 driven outside a mode");
   a_sig: assert property (p_sig) else $error("maker byte wrong");
   a_vlock: assert property (p_vlock) else $error("lock readout wrong");
   a_vsix: assert property (p_vsix) else $error("clock mode readout wrong");
   a_ram: assert property (p_ram) else $error("data RAM gate differs");
   a_tblk: assert property (p_tblk) else $error("table block without cause");
   a_x3: assert property (p_x3) else $error("table read not blocked");
endmodule : epsl_core_sva
bind epsl_core epsl_core_sva #(.SIG_MAKER(SIG_MAKER)) u_sva (.*);

// >>> sim/epsl_prog_model.sv
// Programming system model driving straps, address, data and strobe.
// Assumes port 0 has a pull-up where nobody drives it.
`timescale 1ns/1ns
module epsl_prog_model #(
   parameter int LOW_CYC  = 1000,
   parameter int HIGH_CYC = 100,
   parameter int HOLD_CYC = 80
)
(
   // Clock
   input wire logic  clock,
   // Strap and programming pins
   output logic       rst_pin,
   output logic       program_store_enable,
   output logic       prog_pulse_strobe,
   output logic       external_access_prog_voltage,
   output logic [7:0] port1_in,
   output logic [7:0] port2_in,
   output logic       port3_bit7,
   output logic       port3_bit6,
   output logic       port3_bit3,
   // Port 0 drive
   output logic       data_oe,
   output logic [7:0] data_out
);
   initial begin
      {rst_pin, program_store_enable, external_access_prog_voltage, data_oe} = '0;
      {port1_in, port2_in, data_out, port3_bit7, port3_bit6, port3_bit3} = '0;
      prog_pulse_strobe = 1'b1;
   end
   task automatic pins(input logic [3:0] n, input logic b, input logic [13:0] a);
      rst_pin <= 1'b1;
      {port2_in[7:6], port3_bit7, port3_bit6} <= n;
      port3_bit3 <= b;
      {port2_in[5:0], port1_in} <= a;
   endtask : pins
   task automatic burn(input logic [3:0] n, input logic b, input logic [13:0] a,
                       input logic [7:0] d);
      @(posedge clock);
      pins(n, b, a);
      data_oe <= 1'b1;
      data_out <= d;
      external_access_prog_voltage <= 1'b1;
      repeat (HOLD_CYC) @(posedge clock);
      repeat (5) begin
         prog_pulse_strobe <= 1'b0;
         repeat (LOW_CYC) @(posedge clock);
         prog_pulse_strobe <= 1'b1;
         repeat (HIGH_CYC) @(posedge clock);
      end
      idle();
   endtask : burn
   task automatic verify(input logic [3:0] n, input logic b, input logic [13:0] a);
      @(posedge clock);
      pins(n, b, a);
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask : verify
   task automatic idle();
      rst_pin <= 1'b0;
      external_access_prog_voltage <= 1'b0;
      data_oe <= 1'b0;
      {port2_in[5:0], port1_in} <= ~{port2_in[5:0], port1_in};
   endtask : idle
endmodule : epsl_prog_model

// >>> sim/test_eprom_program_security_logic.sv
// Self-checking bench for the programming and security core.
// Assumes the programmer model and the bound checker.
`timescale 1ns/1ns
module test_eprom_program_security_logic;
   import epsl_pkg::*;
   // Identity bytes: values arbitrary
   localparam logic [7:0] MAKER = 8'h6E;
   localparam logic [7:0] PART  = 8'h2B;
   logic        clock = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00, p1, p2, m_dat, p0;
   logic [31:0] dat = 32'h0, rdat, junk;
   logic        ack, rst_pin, pse, strobe, vpp, p37, p36, p33, m_oe, oe;
   logic        ea = 1'b1, trd = 1'b0, tblk, eaeff, xdis, rdis, six;
   int          error_cnt = 0, tests_run = 0, cycles = 0;
   wire  [7:0]  p0_in = oe ? p0 : (m_oe ? m_dat : 8'hFF);
   always #50 clock = ~clock;
   epsl_prog_model u_prog (.clock(clock), .rst_pin(rst_pin), .program_store_enable(pse),
      .prog_pulse_strobe(strobe), .external_access_prog_voltage(vpp), .port1_in(p1),
      .port2_in(p2), .port3_bit7(p37), .port3_bit6(p36), .port3_bit3(p33), .data_oe(m_oe),
      .data_out(m_dat));
   epsl_core #(.SIG_MAKER(MAKER), .SIG_PART(PART)) u_dut (.clock(clock), .resetn(resetn),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rst_pin(rst_pin),
      .program_store_enable(pse), .prog_pulse_strobe(strobe),
      .external_access_prog_voltage(vpp), .port1_in(p1), .port2_in(p2), .port3_bit7(p37),
      .port3_bit6(p36), .port3_bit3(p33), .port0_in(p0_in), .port0_out(p0), .port0_oe(oe),
      .external_access_pin(ea), .table_read_from_external(trd),
      .code_table_read_instr_block(tblk), .external_access_effective(eaeff),
      .external_exec_disable(xdis), .data_ram_disable(rdis), .six_clock_mode(six));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      @(posedge clock);
      {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
      do @(posedge clock); while (ack !== 1'b1);
      r = rdat;
      {cyc, stb} <= 2'h0;
   endtask : wb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk(n, e, r);
   endtask : rdchk
   task automatic vchk(input logic [3:0] n, input logic b, input logic [13:0] a,
                       input logic [8:0] e);
      u_prog.verify(n, b, a);
      chk("port0", 32'(e), 32'({oe, p0}));
   endtask : vchk
   task automatic t_reset;
      rdchk(REG_STATUS, 32'h30, "status");
      rdchk(8'h10, 32'h0, "unmapped");
      rdchk(REG_CTRL, 32'h1, "ctrl");
      $display("reset test done");
   endtask : t_reset
   task automatic t_code;
      u_prog.burn(NIB_SIX_CLK, 1'b0, 14'h0, 8'h00);
      vchk(4'h1, 1'b1, 14'h0, 9'h1EF);
      chk("six", 32'h1, 32'(six));
      u_prog.burn(NIB_PROG_CODE, 1'b0, 14'h0123, 8'hA5);
      u_prog.burn(NIB_PROG_CODE, 1'b0, 14'h0003, 8'h3C);
      vchk(NIB_VERIFY_CODE, 1'b0, 14'h0123, 9'h1A5);
      wb(1'b1, REG_CODE_ADDR, 32'h3, junk);
      rdchk(REG_CODE_DATA, 32'h3C, "code data");
      vchk(NIB_SIGNATURE, 1'b0, SIG_MAKER_ADDR, {1'b1, MAKER});
      vchk(NIB_SIGNATURE, 1'b0, SIG_PART_ADDR, {1'b1, PART});
      $display("code test done");
   endtask : t_code
   task automatic t_key;
      u_prog.burn(NIB_PROG_ENC, 1'b0, 14'h0003, 8'h0F);
      u_prog.burn(NIB_PROG_ENC, 1'b0, 14'h0003, 8'hFF);
      vchk(NIB_VERIFY_CODE, 1'b0, 14'h0003, 9'h1CC);
      vchk(NIB_VERIFY_CODE, 1'b0, 14'h0123, 9'h1A5);
      rdchk(REG_STATUS, 32'h328, "status");
      $display("key test done");
   endtask : t_key
   task automatic t_lock1;
      u_prog.burn(NIB_LOCK1, 1'b0, 14'h0, 8'h00);
      vchk(4'h2, 1'b1, 14'h0, 9'h17F);
      u_prog.burn(NIB_PROG_CODE, 1'b0, 14'h0004, 8'h00);
      vchk(NIB_VERIFY_CODE, 1'b0, 14'h0004, 9'h1FF);
      rdchk(REG_STATUS, 32'h369, "status");
      u_prog.idle();
      @(posedge clock);
      {ea, trd} <= 2'h1;
      repeat (3) @(posedge clock);
      chk("ea latch", 32'h1, 32'(eaeff));
      chk("table block", 32'h1, 32'(tblk));
      rdchk(REG_CODE_DATA, 32'h0, "code data");
      {ea, trd} <= 2'h2;
      wb(1'b1, REG_CTRL, 32'h3, junk);
      $display("lock one test done");
   endtask : t_lock1
   task automatic t_lock23;
      u_prog.burn(NIB_LOCK2, 1'b0, 14'h0, 8'h00);
      u_prog.verify(NIB_VERIFY_CODE, 1'b0, 14'h0003);
      chk("verify oe", 32'h0, 32'(oe));
      vchk(4'h2, 1'b1, 14'h0, 9'h13F);
      u_prog.burn(NIB_LOCK3, 1'b0, 14'h0, 8'h00);
      vchk(4'h2, 1'b1, 14'h0, 9'h137);
      chk("exec off", 32'h1, 32'(xdis));
      chk("ram off", 32'h1, 32'(rdis));
      @(posedge clock);
      trd <= 1'b1;
      repeat (3) @(posedge clock);
      chk("table block", 32'h1, 32'(tblk));
      trd <= 1'b0;
      $display("lock two and three test done");
   endtask : t_lock23
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      t_reset();
      t_code();
      t_key();
      t_lock1();
      t_lock23();
      complete_run();
   end
endmodule : test_eprom_program_security_logic
